// ### dv/flr_fault_limit_response_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module flr_fault_limit_response_regs_test;
  import flr_pkg::*;
  // short counts keep the run brief
  localparam int RC = 20;
  localparam int OCC = 4;
  localparam flr_meas_t NOM = '{16'h0100, 16'h0000, 16'h0000, 16'h0000};
  localparam flr_meas_t UVL = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam flr_meas_t UVV = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF};
  localparam flr_meas_t OCH = '{16'h0100, 16'hFFFF, 16'h0000, 16'h0000};
  localparam flr_meas_t OTH = '{16'h0100, 16'h0000, 16'hFFFF, 16'h0000};
  localparam flr_meas_t OCW = '{16'h0100, 16'hF820, 16'h0000, 16'h0000};
  typedef struct packed {logic rd; logic err; logic [15:0] data;} flr_exp_t;
  logic ref_clk, rst, en_pin, op_on, sw_cycle, cmd_ack_r, cmd_err_r;
  logic out_en_r, ovc_warn_r, ot_warn_r;
  logic [15:0] cmd_rdata_r, v;
  logic [3:0] fault_r;
  logic [31:0] seed = 32'h6D9B;
  flr_cmd_t cmd;
  flr_meas_t meas;
  flr_exp_t exp_q[$];
  flr_exp_t e;
  int bad_count = 0;
  int samples_checked = 0;
  int n;

  flr_host_model i_host (.ref_clk(ref_clk), .cmd(cmd));
  flr_fault_limit_response_regs #(.RETRY_CYCLES(RC), .OVC_CYCLES(OCC)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .cmd(cmd), .cmd_rdata_r(cmd_rdata_r),
    .cmd_ack_r(cmd_ack_r), .cmd_err_r(cmd_err_r), .en_pin(en_pin), .op_on(op_on),
    .meas(meas), .sw_cycle(sw_cycle), .out_en_r(out_en_r), .fault_r(fault_r),
    .ovc_warn_r(ovc_warn_r), .ot_warn_r(ot_warn_r));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // bounded wait on the stage enable; n counts the negedges spent
  task automatic wait_en(input logic val, input int lim);
    n = 0;
    while (out_en_r !== val) begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("mismatch out_en_r expected %h seen %h", val, out_en_r);
        give_verdict();
      end
    end
  endtask

  task automatic drive(input logic en, input logic op, input flr_meas_t m, input int cyc);
    @(posedge ref_clk);
    en_pin <= en;
    op_on <= op;
    meas <= m;
    repeat (cyc) @(negedge ref_clk);
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      sw_cycle <= 1'b1;
      @(posedge ref_clk);
      sw_cycle <= 1'b0;
    end
    @(negedge ref_clk);
  endtask

  // the expected answer is queued before the strobe goes out
  task automatic host_cmd(input logic wr, input logic rd, input logic [7:0] code,
                          input logic [15:0] wd, input logic err, input logic [15:0] rv);
    exp_q.push_back('{rd, err, rv});
    i_host.send(wr, rd, code, wd);
    @(negedge ref_clk);
  endtask

  // answer watcher pairs each ack with the oldest queued note
  always @(negedge ref_clk) begin
    if (cmd_ack_r === 1'b1) begin
      if (exp_q.size() == 0) chk("cmd_ack_r", 16'h0, 16'h1);
      else begin
        e = exp_q.pop_front();
        chk("cmd_err_r", {15'h0, e.err}, {15'h0, cmd_err_r});
        if (e.rd) chk("cmd_rdata_r", e.data, cmd_rdata_r);
      end
    end
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    chk("run_length", 16'h0, 16'h1);
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    en_pin = 1'b1;
    op_on = 1'b1;
    sw_cycle = 1'b0;
    meas = NOM;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    wait_en(1'b1, 5);
    // defaults, unknown code, random write and read back
    for (int i = 0; i < REG_COUNT; i++) host_cmd(0, 1, REG_CODE[i], 16'h0, 0, REG_RST[i]);
    host_cmd(1, 0, 8'h48, 16'hFFFF, 1, 16'h0);
    host_cmd(0, 1, 8'h48, 16'h0, 1, 16'h0);
    for (int i = 0; i < REG_COUNT; i++) begin
      seed = lfsr(seed);
      v = REG_IS_BYTE[i] ? (seed[15:0] & 16'h00FF) : seed[15:0];
      host_cmd(1, 0, REG_CODE[i], seed[15:0], 0, 16'h0);
      host_cmd(0, 1, REG_CODE[i], 16'h0, 0, v);
      host_cmd(1, 0, REG_CODE[i], REG_RST[i], 0, 16'h0);
    end
    // read in the same cycle as a write returns the old value
    host_cmd(1, 1, CMD_OT_ALERT, 16'h1234, 0, RST_OT_ALERT);
    host_cmd(0, 1, CMD_OT_ALERT, 16'h0, 0, 16'h1234);
    host_cmd(1, 0, CMD_OT_ALERT, RST_OT_ALERT, 0, 16'h0);
    // random settings may have latched; cycle the host enable
    drive(1, 0, NOM, 3);
    drive(1, 1, NOM, 1);
    wait_en(1'b1, 5);
    drive(1, 1, UVL, 1);
    wait_en(1'b0, 5);
    wait_en(1'b1, RC + 5);
    chk("uv_wait", 16'(RC), 16'(n));
    wait_en(1'b0, 5);
    wait_en(1'b1, RC + 5);
    chk("uv_retry", 16'(RC), 16'(n));
    // host off, then latch from another fault
    wait_en(1'b0, 5);
    drive(1, 0, UVL, 3 * RC);
    chk("out_en_r", 16'h0, {15'h0, out_en_r});
    drive(1, 1, NOM, 1);
    wait_en(1'b1, 5);
    drive(1, 1, UVL, 1);
    wait_en(1'b0, 5);
    drive(1, 1, UVV, 3 * RC);
    chk("out_en_r", 16'h0, {15'h0, out_en_r});
    chk("fault_r", 16'h1, {15'h0, fault_r[0]});
    drive(1, 1, NOM, 3 * RC);
    chk("out_en_r", 16'h0, {15'h0, out_en_r});
    drive(0, 1, NOM, 3);
    drive(1, 1, NOM, 1);
    wait_en(1'b1, 5);
    // count then shut, hiccup until clear
    drive(1, 1, OCH, 1);
    pulses(OCC - 1);
    chk("out_en_r", 16'h1, {15'h0, out_en_r});
    pulses(1);
    wait_en(1'b0, 5);
    wait_en(1'b1, RC + 5);
    chk("ovc_wait", 16'(RC), 16'(n));
    pulses(OCC);
    wait_en(1'b0, 5);
    drive(1, 1, NOM, 1);
    wait_en(1'b1, RC + 5);
    pulses(OCC);
    chk("out_en_r", 16'h1, {15'h0, out_en_r});
    // hold while hot, resume when cool
    drive(1, 1, OTH, 1);
    wait_en(1'b0, 5);
    drive(1, 1, OTH, 3 * RC);
    chk("out_en_r", 16'h0, {15'h0, out_en_r});
    chk("ot_warn_r", 16'h1, {15'h0, ot_warn_r});
    drive(1, 1, NOM, 1);
    wait_en(1'b1, 3);
    // written limit trips, ignore reaction does not
    host_cmd(1, 0, CMD_UV_TRIP, 16'h0200, 0, 16'h0);
    wait_en(1'b0, 5);
    host_cmd(1, 0, CMD_UV_REACT, 16'h0000, 0, 16'h0);
    wait_en(1'b1, RC + 5);
    drive(1, 1, OCW, 3 * RC);
    chk("out_en_r", 16'h1, {15'h0, out_en_r});
    chk("ovc_warn_r", 16'h1, {15'h0, ovc_warn_r});
    chk("ot_warn_r", 16'h0, {15'h0, ot_warn_r});
    chk("pending", 16'h0, 16'(exp_q.size()));
    give_verdict();
  end
endmodule
`default_nettype wire

// ### dv/flr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flr_host_model (
  // clock
  input wire logic ref_clk,
  // command strobes toward the device
  output var flr_pkg::flr_cmd_t cmd
);
  import flr_pkg::*;

  initial cmd = '0;

  // one-cycle strobe; idle fields show inverted data so stale values never match
  task automatic send(input logic wr, input logic rd, input logic [7:0] code,
                      input logic [15:0] wdata);
    @(posedge ref_clk);
    cmd <= '{wr: wr, rd: rd, code: code, wdata: wdata};
    @(posedge ref_clk);
    cmd <= '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~wdata};
  endtask
endmodule
`default_nettype wire

// ### verilog/flr_fault_limit_response_regs.sv
// Summary of operation
// - with the default undervoltage reaction the output is shut off and restarted forever.
// - each undervoltage restart attempt follows a fixed 20 ms wait after the shutdown.
// - retrying ends when the host turns the output off or another fault forces a shutdown.
// - the default overcurrent reaction keeps switching for 128 overcurrent cycles first.
// - after an overcurrent shutdown it waits 20 ms and hiccups until overcurrent is gone.
// - the default overtemperature reaction holds the output off and resumes once clear.
// - the default input overvoltage reaction turns the output off and restarts only after the host turns it off and on again.
`timescale 1ns/1ps
`default_nettype none
module flr_fault_limit_response_regs #(
  parameter int RETRY_CYCLES = flr_pkg::RETRY_CYCLES_DFLT,
  parameter int OVC_CYCLES = flr_pkg::OVC_CYCLES_DFLT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // command port
  input wire flr_pkg::flr_cmd_t cmd,
  output logic [15:0] cmd_rdata_r,
  output logic cmd_ack_r,
  output logic cmd_err_r,
  // host on/off requests
  input wire logic en_pin,
  input wire logic op_on,
  // telemetry
  input wire flr_pkg::flr_meas_t meas,
  input wire logic sw_cycle,
  // power stage and flags
  output logic out_en_r,
  output logic [3:0] fault_r,
  output logic ovc_warn_r,
  output logic ot_warn_r
);
  import flr_pkg::*;

  localparam int TW = $clog2(RETRY_CYCLES + 1);
  localparam int CW = $clog2(OVC_CYCLES + 1);

  // command code to storage slot, bit 4 flags a hit
  function automatic logic [4:0] flr_lookup(input logic [7:0] code);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (REG_CODE[i] == code) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  // highest priority set bit
  function automatic logic [1:0] flr_first(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = FLT_COUNT - 1; i >= 0; i--) begin
      if (v[i]) r = 2'(i);
    end
    return r;
  endfunction

  logic [15:0] regs_r [REG_COUNT];
  flr_state_t st_r, st_nxt;
  logic [1:0] src_r, src_nxt;
  logic [TW-1:0] timer_r, timer_nxt;
  logic [CW-1:0] ovc_cnt_r;
  logic [TW-1:0] wait_cnt_r;

  // command decode
  wire [4:0] look = flr_lookup(cmd.code);
  wire look_hit = look[4];
  wire [3:0] look_idx = look[3:0];
  wire run = en_pin & op_on;

  // reaction decode
  flr_act_t act [FLT_COUNT];
  assign act[FLT_VIN] = flr_act_of(regs_r[IDX_VIN_REACT][7:0]);
  assign act[FLT_OT] = flr_act_of(regs_r[IDX_OT_REACT][7:0]);
  assign act[FLT_UV] = flr_act_of(regs_r[IDX_UV_REACT][7:0]);
  assign act[FLT_OVC] = flr_act_of(regs_r[IDX_OVC_REACT][7:0]);

  // limit compares; raw codes, so limit and reading must share one exponent
  // limit crossing
  wire [3:0] flt;
  assign flt[FLT_VIN] = meas.vin > regs_r[IDX_VIN_TRIP];
  assign flt[FLT_OT] = meas.temp > regs_r[IDX_OT_TRIP];
  assign flt[FLT_UV] = (st_r == ST_ON) && (meas.vout < regs_r[IDX_UV_TRIP]);
  assign flt[FLT_OVC] = meas.iout > regs_r[IDX_OVC_TRIP];

  // with the hiccup reaction overcurrent trips only after the cycle count, otherwise at once
  wire ovc_count_done = ovc_cnt_r >= CW'(OVC_CYCLES);
  wire ovc_trip = (act[FLT_OVC] == ACT_HICCUP) ? ovc_count_done : flt[FLT_OVC];

  // per-fault trip and class masks
  wire [3:0] trip;
  wire [3:0] is_hold;
  wire [3:0] is_latch;
  for (genvar g = 0; g < FLT_COUNT; g++) begin : g_flt
    wire lvl = (g == FLT_OVC) ? ovc_trip : flt[g];
    assign trip[g] = lvl && (act[g] != ACT_IGNORE);
    assign is_hold[g] = act[g] == ACT_HOLD;
    assign is_latch[g] = act[g] == ACT_LATCH;
  end
  wire [1:0] sel = flr_first(trip);
  wire [1:0] hold_sel = flr_first(trip & is_hold);
  wire force_latch = |(trip & is_latch);
  wire force_hold = |(trip & is_hold);

  // settings storage, bytes keep the upper half at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    for (int i = 0; i < REG_COUNT; i++) begin
      if (rst) begin
        regs_r[i] <= REG_RST[i];
      end else if (cmd.wr && look_hit && (look_idx == 4'(i))) begin
        regs_r[i] <= REG_IS_BYTE[i] ? {8'h00, cmd.wdata[7:0]} : cmd.wdata;
      end
    end
  end

  // read answer and unknown-code flag one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_rdata_r <= 16'h0000;
      cmd_ack_r <= 1'b0;
      cmd_err_r <= 1'b0;
    end else begin
      cmd_ack_r <= cmd.rd | cmd.wr;
      cmd_err_r <= (cmd.rd | cmd.wr) & ~look_hit;
      if (cmd.rd) cmd_rdata_r <= look_hit ? regs_r[look_idx] : 16'h0000;
    end
  end

  // consecutive overcurrent cycles; cleared by any clean cycle or output off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovc_cnt_r <= '0;
    end else if (st_r != ST_ON) begin
      ovc_cnt_r <= '0;
    end else if (sw_cycle) begin
      ovc_cnt_r <= flt[FLT_OVC] ? (ovc_count_done ? ovc_cnt_r : ovc_cnt_r + 1'b1) : '0;
    end
  end

  // response sequencer
  always_comb begin
    st_nxt = st_r;
    src_nxt = src_r;
    timer_nxt = timer_r;
    unique case (st_r)
      ST_OFF: begin
        if (run) st_nxt = ST_ON;
      end
      ST_ON: begin
        if (!run) begin
          st_nxt = ST_OFF;
        end else if (|trip) begin
          src_nxt = sel;
          unique case (act[sel])
            ACT_RETRY, ACT_HICCUP: begin
              st_nxt = ST_WAIT;
              timer_nxt = TW'(RETRY_CYCLES - 1);
            end
            ACT_HOLD: st_nxt = ST_HOLD;
            ACT_LATCH: st_nxt = ST_LATCH;
            ACT_IGNORE: st_nxt = ST_ON;
          endcase
        end
      end
      ST_WAIT: begin
        if (!run) begin
          st_nxt = ST_OFF;
        end else if (force_latch) begin
          st_nxt = ST_LATCH;
        end else if (force_hold) begin
          st_nxt = ST_HOLD;
          src_nxt = hold_sel;
        end else if (timer_r == '0) begin
          st_nxt = ST_ON;
        end else begin
          timer_nxt = timer_r - 1'b1;
        end
      end
      ST_HOLD: begin
        if (!run) st_nxt = ST_OFF;
        else if (force_latch) st_nxt = ST_LATCH;
        else if (!flt[src_r]) st_nxt = ST_ON;
      end
      ST_LATCH: begin
        // only an off command releases it
        if (!run) st_nxt = ST_OFF;
      end
    endcase
  end

  // state and registered outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_OFF;
      src_r <= 2'h0;
      timer_r <= '0;
      out_en_r <= 1'b0;
      fault_r <= 4'h0;
      ovc_warn_r <= 1'b0;
      ot_warn_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      src_r <= src_nxt;
      timer_r <= timer_nxt;
      out_en_r <= st_nxt == ST_ON;
      fault_r <= flt;
      ovc_warn_r <= meas.iout > regs_r[IDX_OVC_ALERT];
      ot_warn_r <= meas.temp > regs_r[IDX_OT_ALERT];
    end
  end

  // helper: cycles spent in the wait state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) wait_cnt_r <= '0;
    else if (st_r != ST_WAIT) wait_cnt_r <= '0;
    else wait_cnt_r <= wait_cnt_r + 1'b1;
  end

  chk_uv_retry_entry: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_ON && run && trip[FLT_UV] && sel == 2'(FLT_UV) && act[FLT_UV] == ACT_RETRY)
    |=> (st_r == ST_WAIT && !out_en_r))
    else $error("undervoltage did not start a retry");
  chk_retry_delay_len: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_WAIT && st_nxt == ST_ON) |-> (wait_cnt_r == TW'(RETRY_CYCLES - 1)))
    else $error("restart wait length wrong");
  chk_off_stops_retry: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r != ST_OFF && !run) |=> (st_r == ST_OFF && !out_en_r))
    else $error("off command did not stop output");
  chk_force_latch_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_WAIT && run && force_latch) |=> st_r == ST_LATCH)
    else $error("other fault did not end retry");
  chk_ovc_count_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_ON && run && act[FLT_OVC] == ACT_HICCUP && !ovc_count_done && trip[2:0] == 3'h0)
    |=> st_r == ST_ON)
    else $error("overcurrent shut down too early");
  chk_hiccup_attempt: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_WAIT && timer_r == '0 && run && !force_latch && !force_hold)
    |=> (st_r == ST_ON && out_en_r))
    else $error("hiccup restart missing");
  chk_hold_resume: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_HOLD && run && !force_latch) |=>
    (out_en_r == !$past(flt[src_r])))
    else $error("hold state output wrong");
  chk_latch_stays_off: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_LATCH && run) |=> (st_r == ST_LATCH && !out_en_r))
    else $error("latched fault restarted");
  chk_ot_limit_trip: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == ST_ON && run && meas.temp > regs_r[IDX_OT_TRIP] && act[FLT_OT] != ACT_IGNORE)
    |=> !out_en_r)
    else $error("overtemperature limit not enforced");
endmodule
`default_nettype wire

// ### verilog/flr_pkg.sv
`default_nettype none
package flr_pkg;
  // command codes of the held settings
  localparam logic [7:0] CMD_UV_TRIP = 8'h44;
  localparam logic [7:0] CMD_UV_REACT = 8'h45;
  localparam logic [7:0] CMD_OVC_TRIP = 8'h46;
  localparam logic [7:0] CMD_OVC_REACT = 8'h47;
  localparam logic [7:0] CMD_OVC_ALERT = 8'h4A;
  localparam logic [7:0] CMD_OT_TRIP = 8'h4F;
  localparam logic [7:0] CMD_OT_REACT = 8'h50;
  localparam logic [7:0] CMD_OT_ALERT = 8'h51;
  localparam logic [7:0] CMD_VIN_TRIP = 8'h55;
  localparam logic [7:0] CMD_VIN_REACT = 8'h56;
  // non-volatile defaults
  localparam logic [15:0] RST_UV_TRIP = 16'h00F5;
  localparam logic [15:0] RST_UV_REACT = 16'h00B9;
  localparam logic [15:0] RST_OVC_TRIP = 16'hF821;
  localparam logic [15:0] RST_OVC_REACT = 16'h00A1;
  localparam logic [15:0] RST_OVC_ALERT = 16'hF81F;
  localparam logic [15:0] RST_OT_TRIP = 16'h007D;
  localparam logic [15:0] RST_OT_REACT = 16'h00F9;
  localparam logic [15:0] RST_OT_ALERT = 16'h0069;
  localparam logic [15:0] RST_VIN_TRIP = 16'hF81E;
  localparam logic [15:0] RST_VIN_REACT = 16'h00B8;
  // storage indices
  localparam int REG_COUNT = 10;
  localparam int IDX_UV_TRIP = 0;
  localparam int IDX_UV_REACT = 1;
  localparam int IDX_OVC_TRIP = 2;
  localparam int IDX_OVC_REACT = 3;
  localparam int IDX_OVC_ALERT = 4;
  localparam int IDX_OT_TRIP = 5;
  localparam int IDX_OT_REACT = 6;
  localparam int IDX_OT_ALERT = 7;
  localparam int IDX_VIN_TRIP = 8;
  localparam int IDX_VIN_REACT = 9;
  localparam logic [7:0] REG_CODE [REG_COUNT] = '{CMD_UV_TRIP, CMD_UV_REACT, CMD_OVC_TRIP,
    CMD_OVC_REACT, CMD_OVC_ALERT, CMD_OT_TRIP, CMD_OT_REACT, CMD_OT_ALERT, CMD_VIN_TRIP,
    CMD_VIN_REACT};
  localparam logic [15:0] REG_RST [REG_COUNT] = '{RST_UV_TRIP, RST_UV_REACT, RST_OVC_TRIP,
    RST_OVC_REACT, RST_OVC_ALERT, RST_OT_TRIP, RST_OT_REACT, RST_OT_ALERT, RST_VIN_TRIP,
    RST_VIN_REACT};
  // reaction settings are one byte wide
  localparam logic [REG_COUNT-1:0] REG_IS_BYTE = 10'h24A;
  // reaction codes with special behaviour
  localparam logic [7:0] RSP_RETRY_FOREVER = 8'hB9;
  localparam logic [7:0] RSP_HICCUP = 8'hA1;
  localparam logic [7:0] RSP_HOLD_AUTO = 8'hF9;
  localparam logic [7:0] RSP_HOLD_LATCH = 8'hB8;
  // fault slots, highest priority first
  localparam int FLT_COUNT = 4;
  localparam int FLT_VIN = 0;
  localparam int FLT_OT = 1;
  localparam int FLT_UV = 2;
  localparam int FLT_OVC = 3;
  // timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int RETRY_DELAY_MS = 20;
  localparam int RETRY_CYCLES_DFLT = RETRY_DELAY_MS * (CLK_FREQ_HZ / 1000);
  localparam int OVC_CYCLES_DFLT = 128;

  typedef enum logic [2:0] {
    ACT_IGNORE = 3'h0,
    ACT_RETRY = 3'h1,
    ACT_HICCUP = 3'h2,
    ACT_HOLD = 3'h3,
    ACT_LATCH = 3'h4
  } flr_act_t;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_ON = 5'h02,
    ST_WAIT = 5'h04,
    ST_HOLD = 5'h08,
    ST_LATCH = 5'h10
  } flr_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } flr_cmd_t;

  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
    logic [15:0] vin;
  } flr_meas_t;

  // reaction byte to behaviour
  function automatic flr_act_t flr_act_of(input logic [7:0] rsp);
    flr_act_t a;
    if (rsp == RSP_RETRY_FOREVER) a = ACT_RETRY;
    else if (rsp == RSP_HICCUP) a = ACT_HICCUP;
    else if (rsp == RSP_HOLD_AUTO) a = ACT_HOLD;
    else if (rsp == RSP_HOLD_LATCH) a = ACT_LATCH;
    else if (rsp[7:6] == 2'h0) a = ACT_IGNORE;
    else if (rsp[7:6] == 2'h3) a = ACT_HOLD;
    else if (rsp[5:3] == 3'h7) a = ACT_RETRY;
    else a = ACT_LATCH;
    return a;
  endfunction
endpackage
`default_nettype wire
